// ---- logic/axi_lite_jtag_shifter.sv ----
// AXI4-Lite slave that shifts up to 32 bits onto a JTAG chain
`timescale 1ns/1ps
module axi_lite_jtag_shifter
   import jtag_shifter_pkg::*;
(
   // Clock and reset
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   // AXI4-Lite write address
   input wire logic [jtag_shifter_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   // AXI4-Lite write data
   input wire logic [jtag_shifter_pkg::DATA_W-1:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   // AXI4-Lite write response
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // AXI4-Lite read address
   input wire logic [jtag_shifter_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   // AXI4-Lite read data
   output logic [jtag_shifter_pkg::DATA_W-1:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // JTAG pins
   output logic TCK_O,
   output logic TMS_O,
   output logic TDI_O,
   input wire logic TDO_I
);
   import jtag_shifter_pkg::*;
   function automatic logic [DATA_W-1:0] merge_strb(input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v, input logic [3:0] strb);
      logic [DATA_W-1:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction
   // ***************************************************
   // TDO synchroniser, three stages
   // ***************************************************
   logic [2:0] tdo_sync_reg;
   logic tdo_level_reg, tdo_level_next;
   always_comb begin
      tdo_level_next = tdo_level_reg;
      if (tdo_sync_reg[1] == tdo_sync_reg[2]) begin
         tdo_level_next = tdo_sync_reg[2];
      end
   end
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         tdo_sync_reg <= 3'h0;
         tdo_level_reg <= 1'b0;
      end else begin
         tdo_sync_reg <= {tdo_sync_reg[1:0], TDO_I};
         tdo_level_reg <= tdo_level_next;
      end
   end

   // ***************************************************
   // Register file and bus slave
   // ***************************************************
   logic [DATA_W-1:0] count_reg, count_next;
   logic [DATA_W-1:0] tms_reg, tms_next;
   logic [DATA_W-1:0] tdi_reg, tdi_next;
   logic [DATA_W-1:0] tdo_reg, tdo_next;
   logic [DATA_W-1:0] ctrl_reg, ctrl_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic wr_go, rd_go, shift_done, tdo_capture;
   logic [4:0] bit_idx_reg;
   // Write taken when address and data both present and response slot free
   assign wr_go = S_AXI_AWVALID_I && S_AXI_WVALID_I && !bvalid_reg;
   assign rd_go = S_AXI_ARVALID_I && !rvalid_reg;
   assign S_AXI_AWREADY_O = wr_go;
   assign S_AXI_WREADY_O = wr_go;
   assign S_AXI_ARREADY_O = rd_go;
   always_comb begin
      count_next = count_reg;
      tms_next = tms_reg;
      tdi_next = tdi_reg;
      tdo_next = tdo_reg;
      ctrl_next = ctrl_reg;
      bvalid_next = bvalid_reg && !S_AXI_BREADY_I;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg && !S_AXI_RREADY_I;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      if (tdo_capture) begin
         tdo_next[bit_idx_reg] = tdo_level_reg;
      end
      // Hardware clear first, so a host set in the same cycle wins
      if (shift_done) begin
         ctrl_next[CTRL_START_BIT] = 1'b0;
      end
      if (wr_go) begin
         bvalid_next = 1'b1;
         bresp_next = RESP_OKAY;
         case (S_AXI_AWADDR_I)
            OFF_COUNT: count_next = merge_strb(count_reg, S_AXI_WDATA_I, S_AXI_WSTRB_I);
            OFF_TMS: tms_next = merge_strb(tms_reg, S_AXI_WDATA_I, S_AXI_WSTRB_I);
            OFF_TDI: tdi_next = merge_strb(tdi_reg, S_AXI_WDATA_I, S_AXI_WSTRB_I);
            OFF_TDO: tdo_next = merge_strb(tdo_next, S_AXI_WDATA_I, S_AXI_WSTRB_I);
            OFF_CTRL: ctrl_next = merge_strb(ctrl_next, S_AXI_WDATA_I, S_AXI_WSTRB_I);
            default: bresp_next = RESP_SLVERR;
         endcase
      end
      if (rd_go) begin
         rvalid_next = 1'b1;
         rresp_next = RESP_OKAY;
         case (S_AXI_ARADDR_I)
            OFF_COUNT: rdata_next = count_reg;
            OFF_TMS: rdata_next = tms_reg;
            OFF_TDI: rdata_next = tdi_reg;
            OFF_TDO: rdata_next = tdo_reg;
            OFF_CTRL: rdata_next = ctrl_reg;
            default: begin
               rdata_next = REG_RESET;
               rresp_next = RESP_SLVERR;
            end
         endcase
      end
   end
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         count_reg <= REG_RESET;
         tms_reg <= REG_RESET;
         tdi_reg <= REG_RESET;
         tdo_reg <= REG_RESET;
         ctrl_reg <= REG_RESET;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= REG_RESET;
      end else begin
         count_reg <= count_next;
         tms_reg <= tms_next;
         tdi_reg <= tdi_next;
         tdo_reg <= tdo_next;
         ctrl_reg <= ctrl_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
      end
   end
   assign S_AXI_BVALID_O = bvalid_reg;
   assign S_AXI_BRESP_O = bresp_reg;
   assign S_AXI_RVALID_O = rvalid_reg;
   assign S_AXI_RRESP_O = rresp_reg;
   assign S_AXI_RDATA_O = rdata_reg;

   // ***************************************************
   // Shift engine with TCK divider
   // ***************************************************
   shift_state_e state_reg, state_next;
   logic [HALF_W-1:0] div_reg, div_next;
   logic [5:0] left_reg, left_next;
   logic [4:0] bit_idx_next;
   logic tck_reg, tck_next, tms_out_reg, tms_out_next;
   logic tdi_out_reg, tdi_out_next, half_end;
   logic [5:0] req_bits;
   assign half_end = (div_reg == HALF_LAST);
   // Count clipped to one word, zero treated as no work
   assign req_bits = (count_reg > DATA_W'(MAX_BITS)) ? MAX_BITS : count_reg[5:0];
   assign tdo_capture = (state_reg == ST_LOW) && half_end;
   assign shift_done = (state_reg == ST_DONE);
   always_comb begin
      state_next = state_reg;
      div_next = half_end ? '0 : div_reg + 1'b1;
      left_next = left_reg;
      bit_idx_next = bit_idx_reg;
      tck_next = tck_reg;
      tms_out_next = tms_out_reg;
      tdi_out_next = tdi_out_reg;
      case (state_reg)
         ST_IDLE: begin
            div_next = '0;
            tck_next = 1'b0;
            if (ctrl_reg[CTRL_START_BIT]) begin
               bit_idx_next = 5'h0;
               left_next = req_bits;
               if (req_bits == 6'h0) begin
                  state_next = ST_DONE;
               end else begin
                  tms_out_next = tms_reg[0];
                  tdi_out_next = tdi_reg[0];
                  state_next = ST_LOW;
               end
            end
         end
         ST_LOW: begin
            if (half_end) begin
               tck_next = 1'b1;
               left_next = left_reg - 1'b1;
               state_next = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (half_end) begin
               tck_next = 1'b0;
               if (left_reg == 6'h0) begin
                  state_next = ST_DONE;
               end else begin
                  bit_idx_next = bit_idx_reg + 1'b1;
                  tms_out_next = tms_reg[bit_idx_reg + 1'b1];
                  tdi_out_next = tdi_reg[bit_idx_reg + 1'b1];
                  state_next = ST_LOW;
               end
            end
         end
         ST_DONE: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_reg <= ST_IDLE;
         div_reg <= '0;
         left_reg <= 6'h0;
         bit_idx_reg <= 5'h0;
         tck_reg <= 1'b0;
         tms_out_reg <= 1'b0;
         tdi_out_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         div_reg <= div_next;
         left_reg <= left_next;
         bit_idx_reg <= bit_idx_next;
         tck_reg <= tck_next;
         tms_out_reg <= tms_out_next;
         tdi_out_reg <= tdi_out_next;
      end
   end
   assign TCK_O = tck_reg;
   assign TMS_O = tms_out_reg;
   assign TDI_O = tdi_out_reg;
   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking main_cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_N_I);
   property p_idle_tck_low;
      (state_reg == ST_IDLE) |-> !TCK_O;
   endproperty
   a_idle_tck_low: assert property (p_idle_tck_low) else $error("TCK high while idle");
   property p_tck_half_period;
      $rose(TCK_O) |-> TCK_O [*8] ##1 !TCK_O;
   endproperty
   a_tck_half_period: assert property (p_tck_half_period) else $error("TCK high time");
   property p_start_clears;
      (state_reg == ST_IDLE && ctrl_reg[CTRL_START_BIT] && req_bits == 6'h1)
         |-> ##[1:20] !ctrl_reg[CTRL_START_BIT];
   endproperty
   a_start_clears: assert property (p_start_clears) else $error("Start bit stuck");
   property p_no_pins_without_start;
      (state_reg == ST_IDLE && !ctrl_reg[CTRL_START_BIT]) |=> (state_reg == ST_IDLE);
   endproperty
   a_no_pins_without_start: assert property (p_no_pins_without_start)
      else $error("Shift without start");
   property p_first_bits_lsb;
      (state_reg == ST_IDLE && ctrl_reg[CTRL_START_BIT] && req_bits != 6'h0)
         |=> (TMS_O == $past(tms_reg[0])) && (TDI_O == $past(tdi_reg[0]));
   endproperty
   a_first_bits_lsb: assert property (p_first_bits_lsb) else $error("First bit not LSB");
   property p_tdo_stored;
      (tdo_capture && !wr_go) |=> tdo_reg[$past(bit_idx_reg)] == $past(tdo_level_reg);
   endproperty
   a_tdo_stored: assert property (p_tdo_stored) else $error("TDO sample not stored");
   property p_max_bits;
      left_reg <= MAX_BITS;
   endproperty
   a_max_bits: assert property (p_max_bits) else $error("Shift longer than one word");
   property p_write_response;
      wr_go |=> S_AXI_BVALID_O;
   endproperty
   a_write_response: assert property (p_write_response) else $error("No write response");
   property p_pins_stable_idle;
      (state_reg == ST_IDLE && $past(state_reg) == ST_IDLE) |-> $stable(TMS_O) && $stable(TDI_O);
   endproperty
   a_pins_stable_idle: assert property (p_pins_stable_idle) else $error("Idle pins moved");
endmodule

// ---- logic/jtag_shifter_pkg.sv ----
// Constants, register map and state encoding for the AXI4-Lite JTAG shifter
// Function
// - Registers are reached as an AXI4-Lite slave with single-beat reads and writes.
// - Offset 0x00 holds the bit count of the next shift.
// - Offset 0x04 holds the TMS bits, one per TCK cycle.
// - Offset 0x08 holds the TDI bits, one per TCK cycle.
// - Offset 0x0C gathers the TDO samples taken during a shift.
// - Writing one to bit 0 of offset 0x10 starts a shift with the loaded words.
// - Count, TMS and TDI may be written in any order; only the start bit moves the pins.
// - The start bit clears itself when the shift is done.
// - One shift handles at most 32 bits.
// - TCK toggles at the bus clock divided by a build-time ratio.
// - TCK, TMS and TDI all come from the bus clock through the divider.
package jtag_shifter_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFF_COUNT = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_TMS = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_TDI = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_TDO = 5'h0c;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h10;
   localparam int CTRL_START_BIT = 0;
   localparam logic [DATA_W-1:0] REG_RESET = 32'h0;
   localparam logic [5:0] MAX_BITS = 6'h20;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // TCK divide ratio, bus clock cycles per TCK period (even, >= 2)
   localparam int TCK_RATIO = 16;
   localparam int HALF_W = 8;
   localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(TCK_RATIO / 2 - 1);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOW = 2'b01,
      ST_HIGH = 2'b11,
      ST_DONE = 2'b10
   } shift_state_e;
endpackage

// ---- verification/jtag_target_model.sv ----
// Behavioural JTAG target that answers the shifter's pins
`timescale 1ns/1ps
module jtag_target_model (
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   input wire logic load_i,
   input wire logic [31:0] pattern_i,
   output logic tdo_o,
   output logic [31:0] cap_tms_o,
   output logic [31:0] cap_tdi_o,
   output int rises_o,
   output int gap_ns_o
);
   int idx;
   realtime last_rise;
   initial begin
      tdo_o = 1'b0;
      cap_tms_o = 32'h0;
      cap_tdi_o = 32'h0;
      rises_o = 0;
      gap_ns_o = 0;
      idx = 0;
      last_rise = 0;
   end
   // ****************************************
   // Frame start: first TDO bit presented
   // ****************************************
   always @(posedge load_i) begin
      idx = 0;
      rises_o = 0;
      cap_tms_o = 32'h0;
      cap_tdi_o = 32'h0;
      tdo_o = pattern_i[0];
   end
   // Sample TMS and TDI by TCK index
   always @(posedge tck_i) begin
      if (rises_o < 32) begin
         cap_tms_o[rises_o] = tms_i;
         cap_tdi_o[rises_o] = tdi_i;
      end
      gap_ns_o = int'($realtime - last_rise);
      last_rise = $realtime;
      rises_o++;
   end
   // TDO moves on TCK fall; past the pattern it keeps toggling
   always @(negedge tck_i) begin
      idx++;
      tdo_o = (idx < 32) ? pattern_i[idx] : ~tdo_o;
   end
endmodule

// ---- verification/test_axi_lite_jtag_shifter.sv ----
// Self-checking bench for the AXI4-Lite JTAG shifter
`timescale 1ns/1ps
module test_axi_lite_jtag_shifter;
   import jtag_shifter_pkg::*;
   logic clk, rst_n, awv, wv, brdy, arv, rrdy, tck, tms, tdi, tdo, awr, wr, bv, arr, rv, load;
   logic [4:0] awa, ara;
   logic [31:0] wd, rd, pat, ctms, ctdi;
   logic [3:0] strb;
   logic [1:0] br, rr;
   int rises, gap, errors, num_checks, seed;
   logic [4:0] offs [5];
   axi_lite_jtag_shifter dut_u (.MCLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awa),
      .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(strb),
      .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
      .S_AXI_BREADY_I(brdy), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
      .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
      .S_AXI_RREADY_I(rrdy), .TCK_O(tck), .TMS_O(tms), .TDI_O(tdi), .TDO_I(tdo));
   jtag_target_model tgt_u (.tck_i(tck), .tms_i(tms), .tdi_i(tdi), .load_i(load),
      .pattern_i(pat), .tdo_o(tdo), .cap_tms_o(ctms), .cap_tdi_o(ctdi), .rises_o(rises),
      .gap_ns_o(gap));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   function automatic logic [31:0] mask(input int n);
      return (n >= 32) ? 32'hffffffff : ((32'h1 << n) - 32'h1);
   endfunction
   // ****************************************
   // Bus cycles, driven at the falling edge
   // ****************************************
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      @(negedge clk);
      awa = a;
      wd = d;
      awv = 1'b1;
      wv = 1'b1;
      #1;
      while (awr !== 1'b1) begin
         @(negedge clk);
         #1;
      end
      check("wready", {31'h0, wr}, 32'h1);
      @(negedge clk);
      awv = 1'b0;
      wv = 1'b0;
      brdy = 1'b1;
      while (bv !== 1'b1) @(negedge clk);
      r = br;
      @(negedge clk);
      brdy = 1'b0;
   endtask
   task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      @(negedge clk);
      ara = a;
      arv = 1'b1;
      #1;
      while (arr !== 1'b1) begin
         @(negedge clk);
         #1;
      end
      @(negedge clk);
      arv = 1'b0;
      rrdy = 1'b1;
      while (rv !== 1'b1) @(negedge clk);
      d = rd;
      r = rr;
      @(negedge clk);
      rrdy = 1'b0;
   endtask
   // ****************************************
   // One shift with loads in a random order
   // ****************************************
   task automatic run_shift(input int n);
      logic [31:0] v [3];
      logic [31:0] d;
      logic [1:0] r;
      int k, e;
      v[0] = 32'(n);
      v[1] = $random(seed);
      v[2] = $random(seed);
      k = ($random(seed) & 32'h7fff) % 3;
      e = (n > 32) ? 32 : n;
      @(negedge clk);
      pat = $random(seed);
      load = 1'b1;
      @(negedge clk);
      load = 1'b0;
      axi_wr(OFF_TDO, 32'h0, r);
      for (int j = 0; j < 3; j++) axi_wr(offs[(j + k) % 3], v[(j + k) % 3], r);
      check("no tck before start", 32'(rises), 32'h0);
      axi_wr(OFF_CTRL, 32'h1, r);
      d = 32'h1;
      for (int j = 0; j < 400 && d[0] !== 1'b0; j++) axi_rd(OFF_CTRL, d, r);
      check("start cleared", d, 32'h0);
      axi_rd(OFF_TDO, d, r);
      check("tdo capture", d, pat & mask(e));
      check("tms out", ctms, v[1] & mask(e));
      check("tdi out", ctdi, v[2] & mask(e));
      check("tck count", 32'(rises), 32'(e));
      if (e >= 2) check("tck period ns", 32'(gap), 32'(TCK_RATIO * 5));
      check("tck idle", {31'h0, tck}, 32'h0);
   endtask
   initial begin
      #500000;
      errors++;
      report_and_stop();
   end
   initial begin
      logic [31:0] d, x;
      logic [1:0] r;
      int lens [6];
      offs = '{OFF_COUNT, OFF_TMS, OFF_TDI, OFF_TDO, OFF_CTRL};
      lens = '{0, 1, 32, 9, 40, 31};
      {awv, wv, brdy, arv, rrdy, load} = 6'h0;
      {awa, ara, wd, pat} = '0;
      strb = 4'hf;
      errors = 0;
      num_checks = 0;
      seed = 53545;
      rst_n = 1'b0;
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 5; i++) begin
         axi_rd(offs[i], d, r);
         check("reset value", d, REG_RESET);
         check("read resp", {30'h0, r}, {30'h0, RESP_OKAY});
      end
      axi_rd(5'h14, d, r);
      check("unmapped read resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      axi_wr(5'h18, 32'h1, r);
      check("unmapped write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      for (int i = 0; i < 4; i++) begin
         x = $random(seed);
         axi_wr(offs[i], x, r);
         axi_rd(offs[i], d, r);
         check("read back", d, x);
      end
      axi_wr(OFF_TMS, 32'hffffffff, r);
      strb = 4'h5;
      axi_wr(OFF_TMS, 32'h0, r);
      strb = 4'hf;
      axi_rd(OFF_TMS, d, r);
      check("byte lanes", d, 32'hff00ff00);
      @(negedge clk);
      load = 1'b1;
      @(negedge clk);
      load = 1'b0;
      axi_wr(OFF_CTRL, 32'h2, r);
      repeat (40) @(negedge clk);
      check("no start on bit1", 32'(rises), 32'h0);
      axi_rd(OFF_CTRL, d, r);
      check("ctrl storage", d, 32'h2);
      for (int i = 0; i < 6; i++) run_shift(lens[i]);
      for (int i = 0; i < 5; i++) run_shift(($random(seed) & 32'h7fff) % 33);
      report_and_stop();
   end
endmodule
